// file: dio_pkg.sv
// constants for the discrete input / output alarm block
// assumes a 200 MHz hclk and a 32-bit ahb-lite register bus
package dio_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_IN_CFG   = 8'h00;
  localparam logic [7:0] ADDR_THRESH0  = 8'h04;
  localparam logic [7:0] ADDR_THRESH1  = 8'h08;
  localparam logic [7:0] ADDR_OUT_CFG  = 8'h0C;
  localparam logic [7:0] ADDR_DELAY    = 8'h10;
  localparam logic [7:0] ADDR_HOLD     = 8'h14;
  localparam logic [7:0] ADDR_LOW_W    = 8'h18;
  localparam logic [7:0] ADDR_HIGH_W   = 8'h1C;
  localparam logic [7:0] ADDR_COUNT0   = 8'h20;
  localparam logic [7:0] ADDR_COUNT1   = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h28;

  ////////////////////////////////////////////////////////////////////////
  // field positions: input config, per channel stride of four bits
  localparam int IN_EN_BIT     = 0;
  localparam int IN_MODE_BIT   = 1;
  localparam int IN_INV_BIT    = 2;
  localparam int IN_STRIDE     = 4;
  // output config
  localparam int OUT_EN_BIT    = 0;
  localparam int OUT_ON_LSB    = 1;
  localparam int OUT_OFF_LSB   = 3;
  localparam int OUT_INIT_LSB  = 5;
  localparam int OUT_SRC_BIT   = 7;
  // status read bits / clear command bits on write
  localparam int ST_ALARM0_BIT = 0;
  localparam int ST_ALARM1_BIT = 1;
  localparam int ST_LEVEL_BIT  = 2;
  localparam int ST_BUSY_BIT   = 3;

  ////////////////////////////////////////////////////////////////////////
  // encodings and reset values
  localparam logic [1:0] ACT_HIGH  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_PULSE = 2'h2;
  localparam logic [1:0] INIT_LOW  = 2'h0;
  localparam logic [1:0] INIT_HIGH = 2'h1;
  localparam logic [1:0] INIT_LAST = 2'h2;

  localparam logic [7:0]  IN_CFG_RST  = 8'h00;
  localparam logic [15:0] THRESH_RST  = 16'h0000;
  localparam logic [7:0]  OUT_CFG_RST = {1'b0, INIT_LOW, ACT_LOW, ACT_HIGH, 1'b0};
  localparam logic [14:0] DELAY_RST   = 15'h0000;
  localparam logic [7:0]  HOLD_RST    = 8'h00;
  localparam logic [18:0] WIDTH_RST   = 19'h0000A;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS        = 5;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_NS;
  localparam int MS_PER_SEC    = 1000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } dio_state_t;

endpackage

// file: dio_in_chan.sv
// one discrete input channel: level or event counter alarm
// assumes the input pin is already synchronous to hclk
`timescale 1ns/1ps
module dio_in_chan (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        din,
  input  wire logic        en,
  input  wire logic        cnt_mode,
  input  wire logic        inv,
  input  wire logic [15:0] thresh,
  input  wire logic        clr,
  output logic             alarm_q,
  output logic [31:0]      count_q
);
  import dio_pkg::*;

  logic        din_q;
  logic        fired_q;
  logic        rise;
  logic        counting;
  logic [31:0] count_inc;
  logic        hit;
  logic [31:0] count_d;
  logic        fired_d;
  logic        alarm_d;

  ////////////////////////////////////////////////////////////////////////
  assign rise      = din & ~din_q;
  assign counting  = en & cnt_mode & rise;
  assign count_inc = clr ? 32'h00000001 : count_q + 32'h00000001;
  // zero threshold never matches, so it only counts
  assign hit       = counting & (thresh != 16'h0000) & (count_inc == {16'h0000, thresh}) & (~fired_q | clr);
  assign count_d   = counting ? count_inc : (clr ? 32'h00000000 : count_q);
  assign fired_d   = hit | (fired_q & ~clr);
  // disabled channel never alarms
  assign alarm_d   = en & (cnt_mode ? fired_d : (din ^ inv));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      din_q   <= 1'b0;
      fired_q <= 1'b0;
      alarm_q <= 1'b0;
      count_q <= 32'h00000000;
    end
    else
    begin
      din_q   <= din;
      fired_q <= fired_d;
      alarm_q <= alarm_d;
      count_q <= count_d;
    end
  end

endmodule

// file: dio_alarm_top.sv
// discrete input / output alarm controller with ahb-lite registers
// assumes a single 200 MHz clock, synchronous pins, and an outside
// nonvolatile store that saves do_level and returns it on last_level
//
// How it works
// - each input has its own enable, off at reset; disabled gives no alarm.
// - each input picks level mode or counter mode; level mode by default.
// - plain level mode alarms while the input reads one.
// - inverted level mode alarms while the input reads zero; inversion off by default.
// - counter mode counts rising edges and alarms when count reaches threshold.
// - after firing the counter keeps counting but fires again only after a software clear.
// - a threshold of zero never alarms; counting continues.
// - output has an enable, off at reset; disabled output ignores alarms.
// - alarm assertion drives high, low or pulses; high by default.
// - alarm removal drives high, low or pulses; low by default.
// - after reset output starts high, low or last level; low by default.
// - last level option restores the level saved by the outside store.
// - action starts after 0 to 30000 ms delay; zero starts at once.
// - hold time zero keeps the action until the next trigger.
// - pulse low phase lasts 1 to 300000 ms, default 10.
// - pulse high phase lasts 1 to 300000 ms, default 10.
// - output follows the alarm of input one or two; input one by default.
// - software clear resets the event count of a chosen input.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dio_alarm_top #(
  parameter int MS_CYC = dio_pkg::MS_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        first_discrete_input,
  input  wire logic        second_discrete_input,
  input  wire logic        last_level,
  output logic             do_level
);
  import dio_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  in_cfg_q;
  logic [15:0] thresh0_q;
  logic [15:0] thresh1_q;
  logic [7:0]  out_cfg_q;
  logic [14:0] delay_q;
  logic [7:0]  hold_q;
  logic [18:0] low_w_q;
  logic [18:0] high_w_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  logic        hresp_q;
  logic        readyout_q;

  logic [1:0]  alarm;
  logic [31:0] count [2];
  logic [1:0]  clr;
  logic [1:0]  din;

  ////////////////////////////////////////////////////////////////////////
  // bus decode, zero wait state; size is ignored, whole words only
  logic        addr_phase;
  logic        rd_go;
  logic        wr_go;
  logic [7:0]  a_lo;
  logic        in_map;
  logic [31:0] rd_mux;

  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_go      = addr_phase & ~hwrite;
  assign wr_go      = addr_phase & hwrite;
  assign a_lo       = haddr[7:0];
  assign in_map     = (haddr[31:8] == 24'h000000);

  ////////////////////////////////////////////////////////////////////////
  // output action state
  dio_state_t  state_q;
  dio_state_t  state_d;
  logic        out_q;
  logic        init_done_q;
  logic        boot_q;
  logic        last_q;
  logic        saved_lv;
  logic        prev_alarm_q;
  logic        cur_on_q;
  logic        phase_hi_q;
  logic [14:0] delay_cnt_q;
  logic [7:0]  hold_cnt_q;
  logic [18:0] phase_cnt_q;
  logic [17:0] ms_div_q;
  logic [9:0]  sec_div_q;
  logic        ms_tick;
  logic        sec_tick;

  assign rd_mux =
    (a_lo == ADDR_IN_CFG)  ? {24'h000000, in_cfg_q} :
    (a_lo == ADDR_THRESH0) ? {16'h0000, thresh0_q} :
    (a_lo == ADDR_THRESH1) ? {16'h0000, thresh1_q} :
    (a_lo == ADDR_OUT_CFG) ? {24'h000000, out_cfg_q} :
    (a_lo == ADDR_DELAY)   ? {17'h00000, delay_q} :
    (a_lo == ADDR_HOLD)    ? {24'h000000, hold_q} :
    (a_lo == ADDR_LOW_W)   ? {13'h0000, low_w_q} :
    (a_lo == ADDR_HIGH_W)  ? {13'h0000, high_w_q} :
    (a_lo == ADDR_COUNT0)  ? count[0] :
    (a_lo == ADDR_COUNT1)  ? count[1] :
    (a_lo == ADDR_STATUS)  ? {28'h0000000, state_q != ST_IDLE, out_q, alarm} :
    32'h00000000;

  // writes land in the data phase when hwdata is valid
  logic wr_now;
  assign wr_now = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      rdata_q    <= 32'h00000000;
      hresp_q    <= 1'b0;
      readyout_q <= 1'b1;
    end
    else
    begin
      wr_pend_q <= wr_go & in_map;
      wr_addr_q <= a_lo;
      if (rd_go)
      begin
        rdata_q <= in_map ? rd_mux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_cfg_q  <= IN_CFG_RST;
      thresh0_q <= THRESH_RST;
      thresh1_q <= THRESH_RST;
      out_cfg_q <= OUT_CFG_RST;
      delay_q   <= DELAY_RST;
      hold_q    <= HOLD_RST;
      low_w_q   <= WIDTH_RST;
      high_w_q  <= WIDTH_RST;
    end
    else if (wr_now)
    begin
      case (wr_addr_q)
        ADDR_IN_CFG:  in_cfg_q  <= hwdata[7:0];
        ADDR_THRESH0: thresh0_q <= hwdata[15:0];
        ADDR_THRESH1: thresh1_q <= hwdata[15:0];
        ADDR_OUT_CFG: out_cfg_q <= hwdata[7:0];
        ADDR_DELAY:   delay_q   <= hwdata[14:0];
        ADDR_HOLD:    hold_q    <= hwdata[7:0];
        ADDR_LOW_W:   low_w_q   <= hwdata[18:0];
        ADDR_HIGH_W:  high_w_q  <= hwdata[18:0];
        default:      in_cfg_q  <= in_cfg_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input channels
  assign din = {second_discrete_input, first_discrete_input};
  assign clr = (wr_now && wr_addr_q == ADDR_STATUS) ? hwdata[1:0] : 2'b00;

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    dio_in_chan u_chan (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .din      (din[i]),
      .en       (in_cfg_q[i*IN_STRIDE+IN_EN_BIT]),
      .cnt_mode (in_cfg_q[i*IN_STRIDE+IN_MODE_BIT]),
      .inv      (in_cfg_q[i*IN_STRIDE+IN_INV_BIT]),
      .thresh   (i == 0 ? thresh0_q : thresh1_q),
      .clr      (clr[i]),
      .alarm_q  (alarm[i]),
      .count_q  (count[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // free-running ms and s ticks
  assign ms_tick  = (ms_div_q == 18'(MS_CYC - 1));
  assign sec_tick = ms_tick & (sec_div_q == 10'(MS_PER_SEC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_div_q  <= 18'h00000;
      sec_div_q <= 10'h000;
    end
    else
    begin
      ms_div_q <= ms_tick ? 18'h00000 : ms_div_q + 18'h00001;
      if (ms_tick)
      begin
        sec_div_q <= sec_tick ? 10'h000 : sec_div_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output action control
  logic        out_en;
  logic [1:0]  on_act;
  logic [1:0]  off_act;
  logic [1:0]  init_sel;
  logic        src_alarm;
  logic        trig;
  logic [1:0]  act;
  logic        delay_done;
  logic        hold_done;
  logic [18:0] phase_w;
  logic        phase_end;

  assign out_en    = out_cfg_q[OUT_EN_BIT];
  assign on_act    = out_cfg_q[OUT_ON_LSB+:2];
  assign off_act   = out_cfg_q[OUT_OFF_LSB+:2];
  assign init_sel  = out_cfg_q[OUT_INIT_LSB+:2];
  assign src_alarm = out_cfg_q[OUT_SRC_BIT] ? alarm[1] : alarm[0];
  // alarm edges only trigger while enabled
  assign trig      = init_done_q & out_en & (src_alarm != prev_alarm_q);
  assign act       = cur_on_q ? on_act : off_act;
  assign delay_done = (delay_q == 15'h0000) | (ms_tick & (delay_cnt_q + 15'h0001 >= delay_q));
  // hold counts from the trigger, delay included
  assign hold_done = (hold_q != 8'h00) & sec_tick & (hold_cnt_q + 8'h01 >= hold_q);
  assign phase_w   = phase_hi_q ? high_w_q : low_w_q;
  // zero width behaves as one ms so the wave never stalls
  assign phase_end = ms_tick & (phase_cnt_q + 19'h00001 >= phase_w);
  // the store's level is trusted only at the first edge after release
  assign saved_lv  = boot_q ? last_level : last_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_WAIT: state_d = hold_done ? ST_IDLE : (delay_done ? ST_RUN : ST_WAIT);
      ST_RUN:  state_d = hold_done ? ST_IDLE : ST_RUN;
      default: state_d = ST_IDLE;
    endcase
    if (trig)
    begin
      state_d = ST_WAIT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q      <= ST_IDLE;
      out_q        <= 1'b0;
      init_done_q  <= 1'b0;
      boot_q       <= 1'b1;
      last_q       <= 1'b0;
      prev_alarm_q <= 1'b0;
      cur_on_q     <= 1'b0;
      phase_hi_q   <= 1'b1;
      delay_cnt_q  <= 15'h0000;
      hold_cnt_q   <= 8'h00;
      phase_cnt_q  <= 19'h00000;
    end
    else if (!init_done_q)
    begin
      // initial state holds until the output is first enabled, so it can be chosen after reset
      init_done_q  <= out_en;
      boot_q       <= 1'b0;
      last_q       <= saved_lv;
      out_q        <= (init_sel == INIT_HIGH) | ((init_sel == INIT_LAST) & saved_lv);
      prev_alarm_q <= src_alarm;
    end
    else
    begin
      state_q      <= state_d;
      prev_alarm_q <= src_alarm;
      if (trig)
      begin
        cur_on_q    <= src_alarm;
        delay_cnt_q <= 15'h0000;
        hold_cnt_q  <= 8'h00;
        phase_cnt_q <= 19'h00000;
        phase_hi_q  <= 1'b1;
      end
      else
      begin
        if (sec_tick && state_q != ST_IDLE)
        begin
          hold_cnt_q <= hold_cnt_q + 8'h01;
        end
        if (state_q == ST_WAIT && ms_tick)
        begin
          delay_cnt_q <= delay_cnt_q + 15'h0001;
        end
        if (state_q == ST_WAIT && state_d == ST_RUN)
        begin
          out_q <= (act != ACT_LOW);
        end
        else if (state_q == ST_RUN && act == ACT_PULSE)
        begin
          if (hold_done)
          begin
            out_q <= 1'b0;
          end
          else if (phase_end)
          begin
            phase_hi_q  <= ~phase_hi_q;
            phase_cnt_q <= 19'h00000;
            out_q       <= ~phase_hi_q ? 1'b1 : 1'b0;
          end
          else if (ms_tick)
          begin
            phase_cnt_q <= phase_cnt_q + 19'h00001;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hrdata    = rdata_q;
  assign hreadyout = readyout_q;
  assign hresp     = hresp_q;
  assign do_level  = out_q;

endmodule

// file: dio_field.sv
// field side: contacts on both inputs and the slave's level store
// assumes the bench sets the wanted contact levels
`timescale 1ns/1ps
module dio_field (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic want0,
  input  wire logic want1,
  input  wire logic do_level,
  output logic      first_discrete_input,
  output logic      second_discrete_input,
  output logic      last_level
);
  initial
  begin
    first_discrete_input = 1'b0;
    second_discrete_input = 1'b0;
    last_level = 1'b0;
  end
  // contacts move just after the edge, so the pins stay synchronous
  always @(posedge hclk)
  begin
    first_discrete_input <= want0;
    second_discrete_input <= want1;
    // the store keeps its level while the block is held in reset
    if (hresetn)
    begin
      last_level <= do_level;
    end
  end
endmodule

// file: dio_alarm_monitor.sv
// checker for the alarm block: register read-back, alarm status, output moves
// bound to dio_alarm_top; sees its ports only
`timescale 1ns/1ps
module dio_alarm_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        first_discrete_input,
  input wire logic        do_level
);
  import dio_pkg::*;
  localparam logic [31:0] MSK [8] = '{32'hFF, 32'hFFFF, 32'hFFFF, 32'hFF, 32'h7FFF, 32'hFF, 32'h7FFFF, 32'h7FFFF};
  localparam logic [31:0] RST [8] = '{32'(IN_CFG_RST), 32'(THRESH_RST), 32'(THRESH_RST), 32'(OUT_CFG_RST),
                                      32'(DELAY_RST), 32'(HOLD_RST), 32'(WIDTH_RST), 32'(WIDTH_RST)};
  wire         take   = hsel && htrans[1] && hready;
  wire         rd_st  = take && !hwrite && haddr == {24'h0, ADDR_STATUS};
  wire         rd_cfg = take && !hwrite && haddr < 32'h20;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic        en_seen_q;
  logic [31:0] sh_q [8];
  wire         cfg_on  = sh_q[0][2:0] == 3'b001 && sh_q[3][7:0] == 8'h09 && sh_q[4] == 32'h0;
  wire         cfg_dly = sh_q[0][2:0] == 3'b001 && sh_q[3][7:0] == 8'h09 && sh_q[4] == 32'h2;
  // shadow of the config writes; a write lands at the end of its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      en_seen_q <= 1'b0;
      sh_q <= RST;
    end
    else
    begin
      wr_q <= take && hwrite && haddr < 32'h20;
      wa_q <= haddr[7:0];
      en_seen_q <= en_seen_q | sh_q[3][OUT_EN_BIT];
      if (wr_q)
        sh_q[wa_q[4:2]] <= hwdata & MSK[wa_q[4:2]];
    end
////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reg_readback: assert property (rd_cfg |=> hrdata == $past(sh_q[haddr[4:2]]))
    else $error("config read-back differs");
  a_level_plain: assert property (rd_st && sh_q[0][2:0] == 3'b001 && $past(sh_q[0], 2) == sh_q[0]
    && $stable(first_discrete_input) |=> hrdata[ST_ALARM0_BIT] == $past(first_discrete_input))
    else $error("plain level alarm wrong");
  a_level_inv: assert property (rd_st && sh_q[0][2:0] == 3'b101 && $past(sh_q[0], 2) == sh_q[0]
    && $stable(first_discrete_input) |=> hrdata[ST_ALARM0_BIT] == !$past(first_discrete_input))
    else $error("inverted level alarm wrong");
  a_input_off: assert property (rd_st && !sh_q[0][IN_EN_BIT] && $past(sh_q[0], 2) == sh_q[0]
    |=> !hrdata[ST_ALARM0_BIT])
    else $error("disabled input shows alarm");
  a_never_enabled: assert property (!en_seen_q && !sh_q[3][OUT_EN_BIT]
    && sh_q[3][OUT_INIT_LSB+:2] != INIT_LAST |=> do_level == ($past(sh_q[3][OUT_INIT_LSB+:2]) == INIT_HIGH))
    else $error("output left its initial state while never enabled");
  a_on_high: assert property (cfg_on && $rose(first_discrete_input) |-> ##[1:5] do_level)
    else $error("output did not rise on alarm");
  a_off_low: assert property (cfg_on && $fell(first_discrete_input) |-> ##[1:5] !do_level)
    else $error("output did not fall on alarm removal");
  a_delay_wait: assert property (cfg_dly && $rose(first_discrete_input) && !do_level
    |=> !do_level [*8] ##[8:45] do_level)
    else $error("delayed start out of window");
  c_status: cover property (rd_st);
  c_delay: cover property (cfg_dly && $rose(first_discrete_input));
  c_pulse: cover property ($rose(do_level) && sh_q[3][2:1] == ACT_PULSE);
endmodule

bind dio_alarm_top dio_alarm_monitor u_mon (.*);

// file: testbench.sv
// self-checking bench for the alarm block over ahb-lite
// assumes dio_field on the pins; ms shortened to MSC cycles
`timescale 1ns/1ps
module testbench;
  import dio_pkg::*;
  localparam int MSC = 20;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        want0 = 1'b0;
  logic        want1 = 1'b0;
  logic [31:0] hrdata, v;
  logic        hreadyout, hresp, din0, din1, last_level, do_level;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n;
  logic [7:0]  ra [6] = '{ADDR_IN_CFG, ADDR_THRESH0, ADDR_OUT_CFG, ADDR_DELAY, ADDR_LOW_W, 8'h80};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'(OUT_CFG_RST), 32'h0, 32'(WIDTH_RST), 32'h0};
  logic [31:0] oc [7] = '{32'h09, 32'h09, 32'h89, 32'h89, 32'h03, 32'h03, 32'h03};
  logic [6:0]  pn = 7'b1010101;
  logic [6:0]  ol = 7'b0100001;
  always #2.5 hclk = ~hclk;
  dio_alarm_top #(.MS_CYC(MSC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_discrete_input(din0), .second_discrete_input(din1),
    .last_level(last_level), .do_level(do_level));
  dio_field u_field (.hclk(hclk), .hresetn(hresetn), .want0(want0), .want1(want1), .do_level(do_level),
    .first_discrete_input(din0), .second_discrete_input(din1), .last_level(last_level));
////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; read data lands in v
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic pins(input logic p0, input logic p1);
    @(posedge hclk);
    want0 <= p0;
    want1 <= p1;
    repeat (6) @(posedge hclk);
  endtask
  task automatic pulses(input int ch, input int k);
    repeat (k)
    begin
      pins(ch == 0, ch == 1);
      pins(1'b0, 1'b0);
    end
  endtask
  task automatic span(input logic lv);
    n = 0;
    while (do_level === lv && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
////////////////////////////////////////
  // the hold test alone takes one shortened second
  initial
  begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    rst();
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(v, rv[i]);
    end
    bus(1'b1, ADDR_OUT_CFG, {25'h0, INIT_LAST, 5'h00});
    repeat (2) @(posedge hclk);
    chk({31'h0, do_level}, 32'h0);
    bus(1'b1, ADDR_OUT_CFG, {25'h0, INIT_HIGH, 5'h00});
    repeat (2) @(posedge hclk);
    chk({31'h0, do_level}, 32'h1);
    bus(1'b1, ADDR_OUT_CFG, 32'(OUT_CFG_RST));
    repeat (2) @(posedge hclk);
    chk({31'h0, do_level}, 32'h0);
    $display("test reset values done");
    pins(1'b1, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(v & 32'h3, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_IN_CFG, {29'h0, i[1], 2'b01});
      pins(i[0], 1'b0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(v & 32'h1, {31'h0, i[0] ^ i[1]});
    end
    chk({31'h0, do_level}, 32'h0);
    $display("test level inputs done");
    pins(1'b0, 1'b0);
    bus(1'b1, ADDR_IN_CFG, 32'h33);
    bus(1'b1, ADDR_THRESH1, 32'h3);
    bus(1'b1, ADDR_STATUS, 32'h3);
    pulses(0, 3);
    pulses(1, 3);
    bus(1'b0, ADDR_COUNT0, 32'h0);
    chk(v, 32'h3);
    bus(1'b0, ADDR_COUNT1, 32'h0);
    chk(v, 32'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(v & 32'h3, 32'h2);
    pulses(1, 2);
    bus(1'b0, ADDR_COUNT1, 32'h0);
    chk(v, 32'h5);
    bus(1'b1, ADDR_STATUS, 32'h2);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(v & 32'h3, 32'h0);
    bus(1'b0, ADDR_COUNT1, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, ADDR_COUNT0, 32'h0);
    chk(v, 32'h3);
    $display("test counters done");
    bus(1'b1, ADDR_IN_CFG, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, ADDR_OUT_CFG, oc[i]);
      pins(pn[i], 1'b0);
      chk({31'h0, do_level}, {31'h0, ol[i]});
    end
    bus(1'b1, ADDR_OUT_CFG, 32'h9);
    pins(1'b0, 1'b0);
    bus(1'b1, ADDR_DELAY, 32'h2);
    pins(1'b1, 1'b0);
    chk({31'h0, do_level}, 32'h0);
    repeat (2 * MSC) @(posedge hclk);
    chk({31'h0, do_level}, 32'h1);
    $display("test output actions done");
    bus(1'b1, ADDR_DELAY, 32'h0);
    bus(1'b1, ADDR_LOW_W, 32'h3);
    bus(1'b1, ADDR_HIGH_W, 32'h2);
    bus(1'b1, ADDR_OUT_CFG, 32'h5);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    span(1'b1);
    repeat (2)
    begin
      span(1'b0);
      chk(n, 3 * MSC);
      span(1'b1);
      chk(n, 2 * MSC);
    end
    span(1'b0);
    rst();
    @(posedge hclk);
    chk({31'h0, do_level}, 32'h0);
    bus(1'b1, ADDR_OUT_CFG, {25'h0, INIT_LAST, 5'h00});
    repeat (2) @(posedge hclk);
    chk({31'h0, do_level}, 32'h1);
    bus(1'b1, ADDR_IN_CFG, 32'h1);
    bus(1'b1, ADDR_HOLD, 32'h1);
    bus(1'b1, ADDR_OUT_CFG, 32'h15);
    pins(1'b0, 1'b0);
    repeat (MS_PER_SEC * MSC / 2) @(posedge hclk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(v & 32'h8, 32'h8);
    repeat (MS_PER_SEC * MSC / 2 + 2 * MSC) @(posedge hclk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(v & 32'hC, 32'h0);
    $display("test pulse and hold done");
    give_verdict();
  end
endmodule
